// ### verilog/ssec_consts.svh
// Constants for the supervisor serial-memory controller: opcodes, fields, timing
`ifndef SSEC_CONSTS_SVH
`define SSEC_CONSTS_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SSEC_OP_WRITE_ALLOW 8'h06
`define SSEC_OP_FLAG_SET    8'h00
`define SSEC_OP_FORBID      8'h04
`define SSEC_OP_STAT_FETCH  8'h05
`define SSEC_OP_STAT_WRITE  8'h01
`define SSEC_OP_MEM_READ    8'h03
`define SSEC_OP_MEM_WRITE   8'h02

// ----------------------------------------
// Status byte fields and reset values
// ----------------------------------------
`define SSEC_ST_GUARD       7
`define SSEC_ST_FLAG        6
`define SSEC_ST_PERIOD_HI   5
`define SSEC_ST_PERIOD_LO   4
`define SSEC_ST_LOCK_HI     3
`define SSEC_ST_LOCK_LO     2
`define SSEC_RST_GUARD      1'h0
`define SSEC_RST_PERIOD     2'h0
`define SSEC_RST_LOCK       2'h0
`define SSEC_PERIOD_OFF     2'h3
`define SSEC_LOCK_QTR_BASE  13'h1800
`define SSEC_LOCK_HALF_BASE 13'h1000

// ----------------------------------------
// Timing
// ----------------------------------------
`define SSEC_CLK_MHZ        250
`define SSEC_TICK_US        1000
`define SSEC_TICK_CYC       (`SSEC_TICK_US * `SSEC_CLK_MHZ)
`define SSEC_MS_TICKS(ms)   (((ms) * 1000) / `SSEC_TICK_US)
`define SSEC_HOLD_MS        200
`define SSEC_WD_LONG_MS     1400
`define SSEC_WD_MID_MS      600
`define SSEC_WD_SHORT_MS    200
`define SSEC_NV_WRITE_MS    10

`endif

// ### verilog/ssec_pkg.sv
// Types shared by the supervisor serial-memory controller
package ssec_pkg;

  typedef struct packed {
    logic       guard;
    logic       flag;
    logic [1:0] period;
    logic [1:0] lock;
    logic       write_allow_latch;
    logic       busy;
  } ssec_status_t;

endpackage

// ### verilog/ssec_sync.sv
// Two-flop synchroniser for independent level signals
`timescale 1ns/1ns
module ssec_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule

// ### verilog/ssec_dog.sv
// Time base, watchdog and reset hold timer
`timescale 1ns/1ns
`include "ssec_consts.svh"
module ssec_dog #(
  parameter int TICK_CYC = `SSEC_TICK_CYC,
  parameter int CNT_W    = 11
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       supply_ok,
  input  wire logic       kick,
  input  wire logic [1:0] period,
  output logic            tick_ff,
  output logic            rst_act_ff
);
  localparam int TB_W = $clog2(TICK_CYC + 1);
  localparam logic [CNT_W-1:0] HOLD_T  = CNT_W'(`SSEC_MS_TICKS(`SSEC_HOLD_MS));
  localparam logic [CNT_W-1:0] WD_LONG = CNT_W'(`SSEC_MS_TICKS(`SSEC_WD_LONG_MS));
  localparam logic [CNT_W-1:0] WD_MID  = CNT_W'(`SSEC_MS_TICKS(`SSEC_WD_MID_MS));
  localparam logic [CNT_W-1:0] WD_SHRT = CNT_W'(`SSEC_MS_TICKS(`SSEC_WD_SHORT_MS));

  logic [TB_W-1:0]  tb_ff;
  logic [CNT_W-1:0] hold_ff;
  logic [CNT_W-1:0] wd_ff;
  logic [CNT_W-1:0] wd_lim;
  logic             wd_off;
  logic             expire;

  // ----------------------------------------
  // Shared time base
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tb_ff   <= '0;
      tick_ff <= 1'b0;
    end else if (tb_ff == TB_W'(TICK_CYC - 1)) begin // R25
      tb_ff   <= '0;
      tick_ff <= 1'b1;
    end else begin
      tb_ff   <= tb_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  always_comb begin
    unique case (period) // R20
      2'h0:    wd_lim = WD_LONG;
      2'h1:    wd_lim = WD_MID;
      2'h2:    wd_lim = WD_SHRT;
      2'h3:    wd_lim = WD_SHRT;
    endcase
  end
  assign wd_off = (period == `SSEC_PERIOD_OFF);
  assign expire = tick_ff && !wd_off && !rst_act_ff && (wd_ff == wd_lim - 1'b1); // R1 R2

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wd_ff <= '0;
    end else if (kick || rst_act_ff || wd_off) begin // R1
      wd_ff <= '0;
    end else if (tick_ff) begin
      wd_ff <= wd_ff + 1'b1;
    end
  end

  // ----------------------------------------
  // Reset output hold
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_act_ff <= 1'b1; // R4
      hold_ff    <= '0;
    end else if (!supply_ok || expire) begin // R5 R1
      rst_act_ff <= 1'b1;
      hold_ff    <= '0;
    end else if (rst_act_ff && tick_ff) begin
      if (hold_ff == HOLD_T - 1'b1) begin // R4 R5
        rst_act_ff <= 1'b0;
      end else begin
        hold_ff <= hold_ff + 1'b1;
      end
    end
  end
endmodule

// ### verilog/ssec_ctrl.sv
// Supervisor with serial nonvolatile memory: serial slave, status byte, array
`timescale 1ns/1ns
`include "ssec_consts.svh"

// What this block does
// R1 - Falling select edge restarts watchdog; expiry drives reset active.
// R2 - Watchdog period comes from two stored period-select status bits.
// R3 - Status writes refused while guard pin low and guard-enable set.
// R4 - Reset held after power-up until supply good for 200 ms.
// R5 - Supply low asserts reset; release only after 200 ms of good supply.
// R6 - Eight-bit instruction shifted in, one bit per rising serial clock.
// R7 - Host keeps select low through a sequence; raising it ends it.
// R8 - Opcodes, addresses and data travel most significant bit first.
// R9 - First bit taken on first rising clock after select falls.
// R10 - Serial output changes on falling serial clock edges.
// R11 - Serial clock may pause indefinitely; operation resumes where left.
// R12 - Write-allow sets latch, write-forbid clears it; writes need it set.
// R13 - Latch cleared at power-up and after each accepted write.
// R14 - Status read answered at any time, even during a busy write.
// R15 - Status: guard, flag, period pair, lock pair, latch, busy.
// R16 - Busy bit read-only, 1 during nonvolatile write, else 0.
// R17 - 06 sets latch, 00 sets flag, 04 clears latch and flag.
// R18 - 05 reads status, 01 writes period, lock, guard and flag.
// R19 - 03 reads memory, 02 writes memory, from the following address.
// R20 - Period 00 long, 01 medium, 10 short, 11 watchdog off.
// R21 - Read streams bytes, address increments and wraps top to zero.
// R22 - Write-allow only counts if select rises after its eighth bit.
// R23 - Writes start only if select rises right after a data byte ends.
// R24 - Nonvolatile write is a fixed busy interval; writes blocked meanwhile.
// R25 - Watchdog and reset hold share one parameterised time base.
module ssec_ctrl
  import ssec_pkg::*;
#(
  parameter int TICK_CYC = `SSEC_TICK_CYC,
  parameter int NV_TICKS = `SSEC_MS_TICKS(`SSEC_NV_WRITE_MS),
  parameter int ADDR_W   = 13,
  parameter int PAGE_W   = 4
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic serial_clk,
  input  wire logic select_and_kick_n_in,
  input  wire logic serial_in,
  input  wire logic guard_pin_n_in,
  input  wire logic supply_ok_in,
  output logic      serial_out,
  output logic      serial_out_oe,
  output logic      reset_drive_out,
  output logic      reset_drive_oe
);
  localparam int PAGE_BYTES = 1 << PAGE_W;
  localparam int MEM_BYTES  = 1 << ADDR_W;

  // Link side
  logic                  live_ff;
  logic [2:0]            bit_idx_ff;
  logic [2:0]            byte_cnt_ff;
  logic [7:0]            shift_ff;
  logic [7:0]            op_ff;
  logic [7:0]            sdata_ff;
  logic [ADDR_W-1:0]     addr_ff;
  logic [7:0]            page_ff [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask_ff;
  logic                  tog_ff;
  logic [ADDR_W-1:0]     rd_ptr_ff;
  logic [7:0]            out_sh_ff;
  logic                  so_oe_ff;
  logic [2:0]            cur_idx;
  logic [2:0]            cur_bytes;
  logic [7:0]            nxt_byte;
  logic                  byte_done;
  logic                  is_mem_op;
  logic [ADDR_W-1:0]     rd_src;
  logic                  rd_load;
  logic                  st_load;
  ssec_status_t          stat_sck;

  // Core side
  logic [7:0]            mem [MEM_BYTES];
  logic                  sel_on_s;
  logic                  ok_s;
  logic                  wp_n_s;
  logic                  tog_s;
  logic                  cs_prev_ff;
  logic                  seen_ff;
  logic                  frame_end;
  logic                  kick;
  logic                  tick;
  logic                  rst_act;
  logic                  do_allow;
  logic                  do_forbid;
  logic                  do_fset;
  logic                  do_stat;
  logic                  do_mem;
  ssec_status_t          stat_ff;
  logic [15:0]           busy_cnt_ff;
  logic                  rst_out_ff;

  // ----------------------------------------
  // Link clock domain: input shifting
  // ----------------------------------------
  // Frame-live flag; the async clear from select keeps captured fields intact
  // so the core can read them after select rises while the clock is idle.
  always_ff @(posedge serial_clk or posedge select_and_kick_n_in) begin
    if (select_and_kick_n_in) begin
      live_ff <= 1'b0;
    end else begin
      live_ff <= 1'b1;
    end
  end

  assign cur_idx   = live_ff ? bit_idx_ff : 3'h0; // R9
  assign cur_bytes = live_ff ? byte_cnt_ff : 3'h0;
  assign nxt_byte  = {shift_ff[6:0], serial_in}; // R6 R8
  assign byte_done = (cur_idx == 3'h7);
  assign is_mem_op = (op_ff == `SSEC_OP_MEM_READ) || (op_ff == `SSEC_OP_MEM_WRITE);

  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_idx_ff  <= 3'h0;
      byte_cnt_ff <= 3'h0;
      shift_ff    <= 8'h00;
      tog_ff      <= 1'b0;
    end else begin
      bit_idx_ff <= cur_idx + 3'h1; // R6 R11
      shift_ff   <= nxt_byte;
      if (!live_ff) begin
        tog_ff <= ~tog_ff;
      end
      // Saturates: beyond the fourth byte only the byte phase matters
      if (byte_done && cur_bytes != 3'h7) begin
        byte_cnt_ff <= cur_bytes + 3'h1;
      end else begin
        byte_cnt_ff <= cur_bytes;
      end
    end
  end

  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_ff    <= 8'h00;
      sdata_ff <= 8'h00;
      addr_ff  <= '0;
    end else if (byte_done) begin
      if (cur_bytes == 3'h0) begin
        op_ff <= nxt_byte; // R6
      end else if (cur_bytes == 3'h1 && op_ff == `SSEC_OP_STAT_WRITE) begin
        sdata_ff <= nxt_byte;
      end else if (cur_bytes == 3'h1 && is_mem_op) begin
        addr_ff[ADDR_W-1:8] <= nxt_byte[ADDR_W-9:0]; // R19 R8
      end else if (cur_bytes == 3'h2 && is_mem_op) begin
        addr_ff[7:0] <= nxt_byte;
      end else if (op_ff == `SSEC_OP_MEM_WRITE && cur_bytes >= 3'h3) begin
        // Stays inside the page: a long write overwrites earlier bytes
        addr_ff[PAGE_W-1:0] <= PAGE_W'(addr_ff[PAGE_W-1:0] + 1'b1);
      end
    end
  end

  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_ff <= '0;
    end else if (!live_ff) begin
      mask_ff <= '0;
    end else if (byte_done && op_ff == `SSEC_OP_MEM_WRITE && cur_bytes >= 3'h3) begin
      mask_ff[addr_ff[PAGE_W-1:0]] <= 1'b1;
    end
  end

  // Page buffer holds data only; no reset needed
  always_ff @(posedge serial_clk) begin
    if (byte_done && op_ff == `SSEC_OP_MEM_WRITE && cur_bytes >= 3'h3) begin
      page_ff[addr_ff[PAGE_W-1:0]] <= nxt_byte;
    end
  end

  // ----------------------------------------
  // Link clock domain: output shifting
  // ----------------------------------------
  // Loads happen on the falling edge after a byte boundary, so the host
  // sees the first bit before its next rising edge.
  assign rd_load = live_ff && bit_idx_ff == 3'h0 && byte_cnt_ff >= 3'h3 &&
                   op_ff == `SSEC_OP_MEM_READ;
  assign st_load = live_ff && bit_idx_ff == 3'h0 && byte_cnt_ff >= 3'h1 &&
                   op_ff == `SSEC_OP_STAT_FETCH;
  assign rd_src  = (byte_cnt_ff == 3'h3) ? addr_ff : rd_ptr_ff;

  always_ff @(negedge serial_clk or posedge select_and_kick_n_in) begin
    if (select_and_kick_n_in) begin
      so_oe_ff <= 1'b0;
    end else if (rd_load || st_load) begin
      so_oe_ff <= 1'b1;
    end
  end

  // Array is read across domains; its contents only change after select
  // rises, and reads issued during a busy interval already see the new data.
  always_ff @(negedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_sh_ff <= 8'h00;
      rd_ptr_ff <= '0;
    end else if (rd_load) begin
      out_sh_ff <= mem[rd_src]; // R10 R19
      rd_ptr_ff <= rd_src + 1'b1; // R21
    end else if (st_load) begin
      out_sh_ff <= stat_sck; // R14 R15
    end else begin
      out_sh_ff <= {out_sh_ff[6:0], 1'b0}; // R10 R8
    end
  end

  assign serial_out    = out_sh_ff[7];
  assign serial_out_oe = so_oe_ff;

  // Status is refreshed while the opcode shifts in, before it is loaded
  ssec_sync #(.WIDTH(8)) u_sync_stat (
    .clock (serial_clk),
    .rst_n (rst_n),
    .d     (stat_ff),
    .q     (stat_sck)
  );

  // ----------------------------------------
  // Core clock domain: frame end and kick
  // ----------------------------------------
  ssec_sync #(.WIDTH(4)) u_sync_pins (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({~select_and_kick_n_in, supply_ok_in, guard_pin_n_in, tog_ff}),
    .q     ({sel_on_s, ok_s, wp_n_s, tog_s})
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev_ff <= 1'b0;
      seen_ff    <= 1'b0;
    end else begin
      cs_prev_ff <= sel_on_s;
      if (!sel_on_s && cs_prev_ff) begin
        seen_ff <= tog_s;
      end
    end
  end

  assign kick      = !cs_prev_ff && sel_on_s; // R1
  // A frame counts only if it saw clocks and ended on a byte boundary
  assign frame_end = !sel_on_s && cs_prev_ff && (tog_s != seen_ff) &&
                     (bit_idx_ff == 3'h0); // R7 R23

  assign do_allow  = frame_end && byte_cnt_ff == 3'h1 &&
                     op_ff == `SSEC_OP_WRITE_ALLOW; // R17 R22
  assign do_forbid = frame_end && byte_cnt_ff == 3'h1 && op_ff == `SSEC_OP_FORBID;
  assign do_fset   = frame_end && byte_cnt_ff == 3'h1 && op_ff == `SSEC_OP_FLAG_SET;
  assign do_stat   = frame_end && byte_cnt_ff == 3'h2 && op_ff == `SSEC_OP_STAT_WRITE &&
                     stat_ff.write_allow_latch && !stat_ff.busy &&
                     !(stat_ff.guard && !wp_n_s); // R3 R12 R18 R24
  assign do_mem    = frame_end && byte_cnt_ff >= 3'h4 && op_ff == `SSEC_OP_MEM_WRITE &&
                     stat_ff.write_allow_latch && !stat_ff.busy; // R12 R19 R24

  // ----------------------------------------
  // Status and configuration byte
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff.guard  <= `SSEC_RST_GUARD;
      stat_ff.period <= `SSEC_RST_PERIOD;
      stat_ff.lock   <= `SSEC_RST_LOCK;
    end else if (do_stat) begin
      stat_ff.guard  <= sdata_ff[`SSEC_ST_GUARD]; // R18
      stat_ff.period <= sdata_ff[`SSEC_ST_PERIOD_HI:`SSEC_ST_PERIOD_LO]; // R2
      stat_ff.lock   <= sdata_ff[`SSEC_ST_LOCK_HI:`SSEC_ST_LOCK_LO];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff.flag <= 1'b0;
    end else if (do_stat) begin
      stat_ff.flag <= sdata_ff[`SSEC_ST_FLAG];
    end else if (do_fset) begin
      stat_ff.flag <= 1'b1; // R17
    end else if (do_forbid) begin
      stat_ff.flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff.write_allow_latch <= 1'b0; // R13
    end else if (do_allow) begin
      stat_ff.write_allow_latch <= 1'b1; // R12
    end else if (do_forbid || do_stat || do_mem) begin
      stat_ff.write_allow_latch <= 1'b0; // R12 R13
    end
  end

  // ----------------------------------------
  // Nonvolatile write interval
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff.busy <= 1'b0;
      busy_cnt_ff  <= 16'h0000;
    end else if (do_stat || do_mem) begin
      stat_ff.busy <= 1'b1; // R16 R24
      busy_cnt_ff  <= 16'h0000;
    end else if (stat_ff.busy && tick) begin
      if (busy_cnt_ff == 16'(NV_TICKS - 1)) begin // R24
        stat_ff.busy <= 1'b0;
      end else begin
        busy_cnt_ff <= busy_cnt_ff + 16'h0001;
      end
    end
  end

  function automatic logic lock_hit(input logic [1:0] lvl, input logic [ADDR_W-1:0] a);
    unique case (lvl)
      2'h0:    lock_hit = 1'b0;
      2'h1:    lock_hit = (a >= ADDR_W'(`SSEC_LOCK_QTR_BASE));
      2'h2:    lock_hit = (a >= ADDR_W'(`SSEC_LOCK_HALF_BASE));
      2'h3:    lock_hit = 1'b1;
    endcase
  endfunction

  // Whole page commits in one cycle; protected bytes are left untouched
  always_ff @(posedge clock) begin
    if (do_mem) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (mask_ff[i] &&
            !lock_hit(stat_ff.lock, {addr_ff[ADDR_W-1:PAGE_W], PAGE_W'(i)})) begin
          mem[{addr_ff[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= page_ff[i];
        end
      end
    end
  end

  // ----------------------------------------
  // Supervisor reset output
  // ----------------------------------------
  ssec_dog #(.TICK_CYC(TICK_CYC)) u_dog (
    .clock      (clock),
    .rst_n      (rst_n),
    .supply_ok  (ok_s),
    .kick       (kick),
    .period     (stat_ff.period),
    .tick_ff    (tick),
    .rst_act_ff (rst_act)
  );

  // Open-drain pin: driven low while reset is active, released otherwise
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_out_ff <= 1'b0;
    end else begin
      rst_out_ff <= 1'b0;
    end
  end

  assign reset_drive_out = rst_out_ff;
  assign reset_drive_oe  = rst_act; // R4 R5
endmodule

// ### test/ssec_ctrl_chk.sv
// Port assertions for the supervisor serial-memory controller
`timescale 1ns/1ns
module ssec_ctrl_chk #(
  parameter int TICK_CYC = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic select_and_kick_n_in,
  input wire logic supply_ok_in,
  input wire logic serial_out_oe,
  input wire logic reset_drive_out,
  input wire logic reset_drive_oe
);
  localparam int HOLD_MIN = 199 * TICK_CYC;
  localparam int HOLD_MAX = 202 * TICK_CYC + 8;
  int good_ff;
  int kick_ff;
  int hold_ff;

  // ------
  // Cycle counters
  // ------
  // Tick phase and input sync add slack, so bounds reach one tick below and two ticks plus 8 cycles above 200 ticks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) good_ff <= 0;
    else good_ff <= supply_ok_in ? good_ff + 1 : 0;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) kick_ff <= 0;
    else kick_ff <= $fell(select_and_kick_n_in) ? 0 : kick_ff + 1;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) hold_ff <= 0;
    else hold_ff <= (reset_drive_oe && supply_ok_in) ? hold_ff + 1 : 0;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  drive_low_a: assert property (reset_drive_out == 1'b0)
    else $error("reset pin data not low");
  por_hold_a: assert property (!$past(rst_n) |-> reset_drive_oe)
    else $error("reset released at power-up");
  sup_low_a: assert property (!supply_ok_in |-> ##[0:5] reset_drive_oe)
    else $error("supply low without reset");
  hold_min_a: assert property ($fell(reset_drive_oe) |-> good_ff >= HOLD_MIN)
    else $error("reset released early");
  hold_max_a: assert property (hold_ff <= HOLD_MAX)
    else $error("reset held too long");
  dog_min_a: assert property ($rose(reset_drive_oe) |-> good_ff < 8 || kick_ff >= HOLD_MIN)
    else $error("watchdog fired early");
  oe_late_a: assert property ($fell(select_and_kick_n_in) |-> !serial_out_oe [*8])
    else $error("output driven before opcode");
  oe_sel_a: assert property (select_and_kick_n_in |-> !serial_out_oe)
    else $error("output driven while deselected");
endmodule

bind ssec_ctrl ssec_ctrl_chk #(.TICK_CYC(TICK_CYC)) i_chk (
  .clock(clock), .rst_n(rst_n), .select_and_kick_n_in(select_and_kick_n_in),
  .supply_ok_in(supply_ok_in), .serial_out_oe(serial_out_oe),
  .reset_drive_out(reset_drive_out), .reset_drive_oe(reset_drive_oe));

// ### test/ssec_host.sv
// Serial bus master model of the host microcontroller
`timescale 1ns/1ns
module ssec_host (
  output logic serial_clk,
  output logic select_n,
  output logic mosi,
  input  wire logic miso
);
  logic [7:0] rx_byte;
  event       rx_done;

  initial begin
    serial_clk = 1'b0;
    select_n = 1'b1;
    mosi = 1'b0;
  end

  // ------
  // Frame
  // ------
  // Bytes from index skip on are reported; cut drops trailing bits
  task automatic frame(input logic [7:0] tx[$], input int skip, input int cut, input int stall);
    logic [7:0] b;
    int         nb;
    b = 8'h00;
    nb = tx.size() * 8 - cut;
    select_n = 1'b0;
    for (int n = 0; n < nb; n++) begin
      #3 serial_clk = 1'b0;
      mosi = tx[n / 8][7 - n % 8];
      #3 b = {b[6:0], miso};
      serial_clk = 1'b1;
      if (n % 8 == 7 && n / 8 >= skip) begin
        rx_byte = b;
        -> rx_done;
      end
      if (n == stall) #200;
    end
    #3 serial_clk = 1'b0;
    mosi = ~mosi;
    #3 select_n = 1'b1;
    // Core needs several clocks to see the deselect
    #20;
  endtask
endmodule

// ### test/tb_ssec_ctrl.sv
// Self-checking bench for the supervisor serial-memory controller
`timescale 1ns/1ns
module tb_ssec_ctrl;
  localparam int TICK = 4;
  localparam int NVT  = 50;
  logic        clock;
  logic        rst_n;
  logic        guard_pin_n_in;
  logic        supply_ok_in;
  wire         serial_clk, sel_n, mosi, serial_out, serial_out_oe, rst_oe;
  int          errors, total_checks, cyc, t0;
  logic [31:0] seed;
  logic [7:0]  exp_q[$];
  logic [7:0]  nil_q[$];
  logic [7:0]  d[4];
  logic [1:0]  per[4] = '{2'h2, 2'h1, 2'h0, 2'h3};
  int          dog[4] = '{200, 600, 1400, 0};

  ssec_ctrl #(.TICK_CYC(TICK), .NV_TICKS(NVT)) i_dut (
    .clock(clock), .rst_n(rst_n), .serial_clk(serial_clk),
    .select_and_kick_n_in(sel_n), .serial_in(mosi), .guard_pin_n_in(guard_pin_n_in),
    .supply_ok_in(supply_ok_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .reset_drive_out(), .reset_drive_oe(rst_oe));
  // Deselected output shows the inverse, so a late enable corrupts the bytes seen
  ssec_host i_host (.serial_clk(serial_clk), .select_n(sel_n), .mosi(mosi),
    .miso(serial_out_oe ? serial_out : ~serial_out));

  // ------
  // Helpers
  // ------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [7:0] near(input int v, input int nom);
    return (v >= nom - TICK - 8 && v <= nom + TICK + 8) ? 8'h01 : 8'h00;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic send(input logic [7:0] tx[$]);
    i_host.frame(tx, 99, 0, -1);
  endtask
  // Status byte repeats, so two copies are expected
  task automatic fetch(input logic [7:0] want);
    exp_q.push_back(want);
    exp_q.push_back(want);
    i_host.frame({8'h05, 8'h00, 8'h00}, 1, 0, -1);
  endtask
  task automatic settle();
    repeat (NVT * TICK + 20) @(posedge clock);
  endtask
  task automatic wr_stat(input logic [7:0] v);
    send({8'h06});
    send({8'h01, v});
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v[$], input int cut);
    send({8'h06});
    i_host.frame({8'h02, a[15:8], a[7:0], v}, 99, cut, -1);
    settle();
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] want[$], input int stall);
    logic [7:0] tx[$];
    tx = {8'h03, a[15:8], a[7:0]};
    foreach (want[i]) begin
      exp_q.push_back(want[i]);
      tx.push_back(8'hFF);
    end
    i_host.frame(tx, 3, 0, stall);
  endtask
  task automatic wait_rst(input logic lvl, input int lim);
    for (int n = 0; n < lim && rst_oe !== lvl; n++) @(posedge clock);
  endtask

  always #2 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  always @(i_host.rx_done) begin
    if (exp_q.size() > 0)
      check(i_host.rx_byte, exp_q.pop_front());
    else
      check(8'h00, 8'hFF);
  end
  initial begin
    #160000;
    errors++;
    give_verdict();
  end

  // ------
  // Tests
  // ------
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    guard_pin_n_in = 1'b1;
    supply_ok_in = 1'b1;
    errors = 0;
    total_checks = 0;
    cyc = 0;
    seed = 32'h4DB557E9;
    foreach (d[i]) d[i] = rnd();
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t0 = cyc;
    repeat (2) @(posedge clock);
    fetch(8'h00);
    wait_rst(1'b0, 300 * TICK);
    check(near(cyc - t0, 200 * TICK), 8'h01);
    $display("power-up done");
    send({8'h06});
    fetch(8'h02);
    send({8'h00});
    fetch(8'h42);
    send({8'h04});
    fetch(8'h00);
    send({8'h01, 8'h20});
    fetch(8'h00);
    send({8'h06, 8'h01, 8'h20});
    fetch(8'h00);
    wr_stat(8'h20);
    fetch(8'h21);
    settle();
    fetch(8'h20);
    $display("commands done");
    wr_stat(8'hA0);
    settle();
    @(posedge clock) guard_pin_n_in <= 1'b0;
    wr_stat(8'h10);
    fetch(8'hA2);
    @(posedge clock) guard_pin_n_in <= 1'b1;
    repeat (4) @(posedge clock);
    send({8'h01, 8'h20});
    fetch(8'h21);
    settle();
    $display("guard done");
    wr(16'h001E, {d[0], d[1], d[2]}, 0);
    fetch(8'h20);
    rd(16'h001E, {d[0], d[1]}, 12);
    rd(16'h0010, {d[2]}, -1);
    wr(16'h1FFF, {d[3]}, 0);
    wr(16'h0000, {d[1]}, 0);
    rd(16'h1FFF, {d[3], d[1]}, -1);
    wr_stat(8'h24);
    settle();
    fetch(8'h24);
    wr(16'h1FFF, {~d[3]}, 0);
    rd(16'h1FFF, {d[3]}, -1);
    wr(16'h0000, {d[2]}, 4);
    rd(16'h0000, {d[1]}, -1);
    $display("memory done");
    for (int i = 0; i < 4; i++) begin
      wr_stat({2'h0, per[i], 4'h0});
      settle();
      t0 = cyc;
      send(nil_q);
      wait_rst(1'b1, 1500 * TICK);
      if (i < 3) begin
        check(near(cyc - t0, dog[i] * TICK), 8'h01);
        t0 = cyc;
        wait_rst(1'b0, 300 * TICK);
        check(near(cyc - t0, 200 * TICK), 8'h01);
      end else begin
        check({7'h0, rst_oe}, 8'h00);
      end
    end
    $display("watchdog done");
    @(posedge clock) supply_ok_in <= 1'b0;
    repeat (10) @(posedge clock);
    check({7'h0, rst_oe}, 8'h01);
    supply_ok_in <= 1'b1;
    t0 = cyc;
    wait_rst(1'b0, 300 * TICK);
    check(near(cyc - t0, 200 * TICK), 8'h01);
    check(8'(exp_q.size()), 8'h00);
    $display("supply done");
    give_verdict();
  end
endmodule
